//--- tb/dcsf_fifo_asserts.sv
`timescale 1ns/1ps
module dcsf_fifo_asserts (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic write_clk_i,
  input wire logic read_clk_i,
  input wire logic fifo_reset_n_i,
  input wire logic second_enable_or_load_pin_i,
  input wire logic output_enable_n_i,
  input wire logic [dcsf_pkg::DATA_W-1:0] read_data_o,
  input wire logic read_data_oe_o,
  input wire logic empty_flag_n_o,
  input wire logic almost_empty_flag_n_o,
  input wire logic full_flag_n_o,
  input wire logic almost_full_flag_n_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_reset_flags: assert property (!fifo_reset_n_i [*4] |=>
    full_flag_n_o && almost_full_flag_n_o && !empty_flag_n_o && !almost_empty_flag_n_o)
    else $error("reset flags");
  a_oe_release: assert property ($rose(output_enable_n_i) |-> ##2 !read_data_oe_o)
    else $error("bus not released");
  a_oe_drive: assert property ($fell(output_enable_n_i) |-> ##2 read_data_oe_o)
    else $error("bus not driven");
  a_empty_hold: assert property (!empty_flag_n_o && fifo_reset_n_i
    && second_enable_or_load_pin_i |=> $stable(read_data_o)) else $error("read when empty");
  a_full_wclk: assert property ($changed(full_flag_n_o) && fifo_reset_n_i
    && $past(fifo_reset_n_i, 6) |-> $past(write_clk_i, 3)) else $error("full off clock");
  a_empty_rclk: assert property ($changed(empty_flag_n_o) && fifo_reset_n_i
    && $past(fifo_reset_n_i, 6) |-> $past(read_clk_i, 3)) else $error("empty off clock");
  a_full_almost: assert property (!full_flag_n_o |-> !almost_full_flag_n_o)
    else $error("full not almost");
  a_empty_almost: assert property (!empty_flag_n_o |-> !almost_empty_flag_n_o)
    else $error("empty not almost");
endmodule
bind dcsf_fifo dcsf_fifo_asserts u_chk (.*);

//--- tb/dcsf_port_agent.sv
`timescale 1ns/1ps
module dcsf_port_agent (
  output logic wclk_o,
  output logic [8:0] wdata_o,
  output logic wr_en_n_o,
  output logic rclk_o,
  output logic rd_en_n_o
);
  initial begin
    wclk_o = 1'b0;
    wdata_o = 9'h000;
    wr_en_n_o = 1'b1;
    rclk_o = 1'b0;
    rd_en_n_o = 1'b1;
  end
  task automatic wr(input logic [8:0] d, input logic en_n);
    #1;
    wdata_o = d;
    wr_en_n_o = en_n;
    #31 wclk_o = 1'b1;
    #32 wclk_o = 1'b0;
    wdata_o = ~d;
    wr_en_n_o = 1'b1;
  endtask
  task automatic rd(input logic en_n);
    #1;
    rd_en_n_o = en_n;
    #31 rclk_o = 1'b1;
    #32 rclk_o = 1'b0;
    rd_en_n_o = 1'b1;
  endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic frst_n = 1'b0;
  logic load_n = 1'b1;
  logic oe_n = 1'b0;
  logic ren_b_n = 1'b0;
  logic wclk, wen_n, rclk, ren_n, oe, e_n, ae_n, f_n, af_n;
  logic [8:0] wd, rdata;
  logic [31:0] seed = 32'h6617747B;
  logic [8:0] exp_q[$];
  bit take;
  int miscompares = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  dcsf_port_agent ag (.wclk_o(wclk), .wdata_o(wd), .wr_en_n_o(wen_n), .rclk_o(rclk),
    .rd_en_n_o(ren_n));
  dcsf_fifo #(.DEPTH(64)) dut (.ref_clk_i(clk), .rstn_i(rstn), .write_clk_i(wclk),
    .write_data_i(wd), .write_enable_primary_n_i(wen_n), .second_enable_or_load_pin_i(load_n),
    .fifo_reset_n_i(frst_n), .read_clk_i(rclk), .read_enable_a_n_i(ren_n),
    .read_enable_b_n_i(ren_b_n), .output_enable_n_i(oe_n), .read_data_o(rdata),
    .read_data_oe_o(oe), .empty_flag_n_o(e_n), .almost_empty_flag_n_o(ae_n),
    .full_flag_n_o(f_n), .almost_full_flag_n_o(af_n));
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic put();
    seed = lfsr(seed);
    exp_q.push_back(seed[8:0]);
    ag.wr(seed[8:0], 1'b0);
  endtask
  task automatic get(input logic en_n, input bit t);
    take = t;
    ag.rd(en_n);
  endtask
  always @(posedge rclk) begin
    if (take) begin
      repeat (5) @(posedge clk);
      chk(rdata, exp_q.pop_front());
    end
  end
  initial begin
    #60000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    frst_n <= 1'b1;
    repeat (4) @(posedge clk);
    load_n <= 1'b0;
    ag.wr(9'h1AA, 1'b0);
    @(posedge clk) load_n <= 1'b1;
    for (int i = 1; i <= 64; i++) begin
      put();
      chk({f_n, af_n}, {i != 64, i < 57});
    end
    ag.wr(9'h155, 1'b0);
    get(1'b1, 1'b0);
    // second read enable high blocks read
    @(posedge clk) ren_b_n <= 1'b1;
    get(1'b0, 1'b0);
    @(posedge clk) ren_b_n <= 1'b0;
    for (int i = 63; i >= 0; i--) begin
      get(1'b0, 1'b1);
      chk({e_n, ae_n}, {i != 0, i > 7});
    end
    get(1'b0, 1'b0);
    @(posedge clk) oe_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(oe, 1'b0);
    oe_n <= 1'b0;
    load_n <= 1'b0;
    frst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(oe, 1'b1);
    frst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 4; k++) ag.wr(k[0] ? 9'h000 : 9'h003, 1'b0);
    @(posedge clk) load_n <= 1'b1;
    repeat (4) put();
    get(1'b1, 1'b0);
    chk({e_n, ae_n}, 9'h003);
    @(posedge clk) load_n <= 1'b0;
    exp_q.push_front(9'h003);
    get(1'b0, 1'b1);
    @(posedge clk) load_n <= 1'b1;
    get(1'b0, 1'b1);
    chk({e_n, ae_n}, 9'h002);
    repeat (3) get(1'b0, 1'b1);
    chk(9'(exp_q.size()), 9'h000);
    give_verdict();
  end
endmodule

//--- verilog/dcsf_fifo.sv
`timescale 1ns/1ps
module dcsf_fifo #(
  parameter int DEPTH = 64
) (
  // system
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // write port pins
  input wire logic write_clk_i,
  input wire logic [dcsf_pkg::DATA_W-1:0] write_data_i,
  input wire logic write_enable_primary_n_i,
  input wire logic second_enable_or_load_pin_i,
  input wire logic fifo_reset_n_i,
  // read port pins
  input wire logic read_clk_i,
  input wire logic read_enable_a_n_i,
  input wire logic read_enable_b_n_i,
  input wire logic output_enable_n_i,
  output logic [dcsf_pkg::DATA_W-1:0] read_data_o,
  output logic read_data_oe_o,
  // flags
  output logic empty_flag_n_o,
  output logic almost_empty_flag_n_o,
  output logic full_flag_n_o,
  output logic almost_full_flag_n_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [dcsf_pkg::SYNC_W-1:0] s1;
    logic [dcsf_pkg::SYNC_W-1:0] s2;
    logic wclk_prev;
    logic rclk_prev;
    logic [DEPTH-1:0][dcsf_pkg::DATA_W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [dcsf_pkg::DATA_W-1:0] rdata;
    logic empty_n;
    logic almost_empty_n;
    logic full_n;
    logic almost_full_n;
    logic mode;
    logic [dcsf_pkg::OFF_W-1:0] ae_off;
    logic [dcsf_pkg::OFF_W-1:0] af_off;
    dcsf_pkg::dcsf_seq_t seq;
  } dcsf_state_t;

  dcsf_state_t q;
  dcsf_state_t d;

  function automatic dcsf_pkg::dcsf_seq_t dcsf_seq_next(input dcsf_pkg::dcsf_seq_t s);
    dcsf_pkg::dcsf_seq_t n;
    n = s;
    unique case (s)
      dcsf_pkg::SEQ_AE_LO: n = dcsf_pkg::SEQ_AE_HI;
      dcsf_pkg::SEQ_AE_HI: n = dcsf_pkg::SEQ_AF_LO;
      dcsf_pkg::SEQ_AF_LO: n = dcsf_pkg::SEQ_AF_HI;
      dcsf_pkg::SEQ_AF_HI: n = dcsf_pkg::SEQ_AE_LO;
    endcase
    return n;
  endfunction

  logic [dcsf_pkg::SYNC_W-1:0] pins;
  logic wedge;
  logic redge;
  logic load_low;
  logic wen_ok;
  logic fifo_wr;
  logic off_wr;
  logic rd_req;
  logic fifo_rd;
  logic off_rd;
  logic [AW:0] cnt;
  logic [16:0] lvl;
  logic [7:0] off_byte;

  assign pins = {write_data_i, fifo_reset_n_i, output_enable_n_i, read_enable_b_n_i,
                 read_enable_a_n_i, second_enable_or_load_pin_i, write_enable_primary_n_i,
                 read_clk_i, write_clk_i};

  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.wclk_prev = q.s2[dcsf_pkg::SY_WCLK];
    d.rclk_prev = q.s2[dcsf_pkg::SY_RCLK];
    // port clocks sampled on ref_clk_i in one vector with the other pins
    // rising edges of the sampled port clocks
    wedge = q.s2[dcsf_pkg::SY_WCLK] & ~q.wclk_prev;
    redge = q.s2[dcsf_pkg::SY_RCLK] & ~q.rclk_prev;
    load_low = ~q.s2[dcsf_pkg::SY_WRITE_ENABLE_SECONDARY];
    if (q.mode == dcsf_pkg::MODE_DUAL) begin
      wen_ok = ~q.s2[dcsf_pkg::SY_WRITE_ENABLE_PRIMARY_N] & q.s2[dcsf_pkg::SY_WRITE_ENABLE_SECONDARY];
    end else begin
      wen_ok = ~q.s2[dcsf_pkg::SY_WRITE_ENABLE_PRIMARY_N] & ~load_low;
    end
    off_wr = wedge & (q.mode != dcsf_pkg::MODE_DUAL) & load_low & ~q.s2[dcsf_pkg::SY_WRITE_ENABLE_PRIMARY_N];
    fifo_wr = wedge & wen_ok & q.full_n;
    rd_req = redge & ~q.s2[dcsf_pkg::SY_READ_ENABLE_A_N] & ~q.s2[dcsf_pkg::SY_READ_ENABLE_B_N];
    off_rd = rd_req & (q.mode != dcsf_pkg::MODE_DUAL) & load_low;
    fifo_rd = rd_req & ~off_rd & q.empty_n;
    unique case (q.seq)
      dcsf_pkg::SEQ_AE_LO: off_byte = q.ae_off[7:0];
      dcsf_pkg::SEQ_AE_HI: off_byte = q.ae_off[15:8];
      dcsf_pkg::SEQ_AF_LO: off_byte = q.af_off[7:0];
      dcsf_pkg::SEQ_AF_HI: off_byte = q.af_off[15:8];
    endcase
    cnt = '0;
    lvl = '0;
    if (~q.s2[dcsf_pkg::SY_RST]) begin
      d.wp = '0;
      d.rp = '0;
      d.rdata = '0;
      d.empty_n = 1'b0;
      d.almost_empty_n = 1'b0;
      d.full_n = 1'b1;
      d.almost_full_n = 1'b1;
      d.mode = q.s2[dcsf_pkg::SY_WRITE_ENABLE_SECONDARY];
      d.ae_off = dcsf_pkg::DEF_AE_OFF;
      d.af_off = dcsf_pkg::DEF_AF_OFF;
      d.seq = dcsf_pkg::SEQ_AE_LO;
    end else begin
      if (fifo_wr) begin
        d.mem[q.wp[AW-1:0]] = q.s2[dcsf_pkg::SY_DATA +: dcsf_pkg::DATA_W];
        d.wp = q.wp + 1'b1;
      end
      if (fifo_rd) begin
        d.rdata = q.mem[q.rp[AW-1:0]];
        d.rp = q.rp + 1'b1;
      end
      if (off_wr) begin
        unique case (q.seq)
          dcsf_pkg::SEQ_AE_LO: d.ae_off[7:0] = q.s2[dcsf_pkg::SY_DATA +: 8];
          dcsf_pkg::SEQ_AE_HI: d.ae_off[15:8] = q.s2[dcsf_pkg::SY_DATA +: 8];
          dcsf_pkg::SEQ_AF_LO: d.af_off[7:0] = q.s2[dcsf_pkg::SY_DATA +: 8];
          dcsf_pkg::SEQ_AF_HI: d.af_off[15:8] = q.s2[dcsf_pkg::SY_DATA +: 8];
        endcase
      end
      if (off_rd) begin
        d.rdata = {1'b0, off_byte};
      end
      if (~load_low) begin
        d.seq = dcsf_pkg::SEQ_AE_LO;
      end else if (off_wr | off_rd) begin
        d.seq = dcsf_seq_next(q.seq);
      end
      cnt = d.wp - d.rp;
      lvl = 17'(cnt);
      if (wedge) begin
        d.full_n = (lvl != 17'(DEPTH));
        d.almost_full_n = ((lvl + 17'(q.af_off)) < 17'(DEPTH));
      end
      if (redge) begin
        d.empty_n = (cnt != '0);
        d.almost_empty_n = (lvl > 17'(q.ae_off));
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.full_n <= 1'b1;
      q.almost_full_n <= 1'b1;
      q.ae_off <= dcsf_pkg::DEF_AE_OFF;
      q.af_off <= dcsf_pkg::DEF_AF_OFF;
      q.mode <= dcsf_pkg::MODE_DUAL;
    end else begin
      q <= d;
    end
  end

  assign read_data_o = q.rdata;
  assign read_data_oe_o = ~q.s2[dcsf_pkg::SY_OE];
  assign empty_flag_n_o = q.empty_n;
  assign almost_empty_flag_n_o = q.almost_empty_n;
  assign full_flag_n_o = q.full_n;
  assign almost_full_flag_n_o = q.almost_full_n;

endmodule

//--- verilog/dcsf_pkg.sv
package dcsf_pkg;
  // data path width
  localparam int DATA_W = 9;
  // offset register width, loaded as two bytes
  localparam int OFF_W = 16;
  // offsets that reset leaves in place
  localparam logic [15:0] DEF_AE_OFF = 16'h0007;
  localparam logic [15:0] DEF_AF_OFF = 16'h0007;
  // level of the shared pin at reset that selects dual write enables
  localparam logic MODE_DUAL = 1'b1;
  // bit positions of the sampled input vector
  localparam int SY_WCLK = 0;
  localparam int SY_RCLK = 1;
  localparam int SY_WRITE_ENABLE_PRIMARY_N = 2;
  localparam int SY_WRITE_ENABLE_SECONDARY = 3;
  localparam int SY_READ_ENABLE_A_N = 4;
  localparam int SY_READ_ENABLE_B_N = 5;
  localparam int SY_OE = 6;
  localparam int SY_RST = 7;
  localparam int SY_DATA = 8;
  localparam int SYNC_W = SY_DATA + DATA_W;
  // offset load and read sequence
  typedef enum logic [1:0] {
    SEQ_AE_LO = 2'h0,
    SEQ_AE_HI = 2'h1,
    SEQ_AF_LO = 2'h3,
    SEQ_AF_HI = 2'h2
  } dcsf_seq_t;
endpackage
